// [verilog/smc_params.svh]
// Purpose: timing constants of the standby mode controller
// Assumes: clk_sys runs at 40 MHz and keeps running in every sleep mode
// Notes: definitions only
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH

// ****************************************
// clock and stabilization timing
// ****************************************
`define SMC_CLK_PERIOD_NS 25
// oscillation stabilization wait after deep sleep on the crystal source
`define SMC_STAB_TIME_NS 6400
// least time, so the cycle count rounds up
`define SMC_STAB_CYC ((`SMC_STAB_TIME_NS + `SMC_CLK_PERIOD_NS - 1) / `SMC_CLK_PERIOD_NS)
`define SMC_STAB_W 9

`endif

// [verilog/smc_pkg.sv]
// Purpose: types of the standby mode controller
// Assumes: nothing beyond the params header
// Notes: one-hot state codes
`default_nettype none

package smc_pkg;
   // ****************************************
   // controller states
   // ****************************************
   typedef enum logic [3:0] {
      SMC_ST_RUN  = 4'h1,
      SMC_ST_HALT = 4'h2,
      SMC_ST_STOP = 4'h4,
      SMC_ST_WAIT = 4'h8
   } smc_state_t;
endpackage: smc_pkg

`default_nettype wire

// [verilog/smc_if.sv]
// Purpose: start/done link between controller and stabilization timer
// Assumes: both ends on clk_sys
// Notes: start is a level held for the whole wait
`timescale 1ns/1ps
`default_nettype none

interface smc_if;
   logic start;
   logic done;
   modport ctl (output start, input done);
   modport tmr (input start, output done);
endinterface: smc_if

`default_nettype wire

// [verilog/smc_stab_timer.sv]
// Purpose: counts the oscillation stabilization wait
// Assumes: start stays high until done has been seen
// Notes: done rises in the last cycle of the wait
`timescale 1ns/1ps
`default_nettype none
`include "smc_params.svh"

module smc_stab_timer (
   input wire logic clk_sys,
   input wire logic reset_n,
   smc_if.tmr tif
);
   localparam logic [`SMC_STAB_W-1:0] LAST_CNT = `SMC_STAB_W'(`SMC_STAB_CYC - 1);

   logic [`SMC_STAB_W-1:0] cnt;
   logic [`SMC_STAB_W-1:0] next_cnt;

   // ****************************************
   // counter
   // ****************************************
   // clear whenever idle so each wait starts from zero
   always_comb begin
      next_cnt = '0;
      if (tif.start && cnt != LAST_CNT) begin
         next_cnt = cnt + `SMC_STAB_W'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

   // handshake output may be combinational
   assign tif.done = tif.start && (cnt == LAST_CNT);
endmodule: smc_stab_timer

`default_nettype wire

// [verilog/standby_mode_controller.sv]
// Purpose: light and deep sleep control for an 8-bit core
// Assumes: clk_sys is a free-running low-level clock, separate from the gated core clock
// Notes: all outputs are registered and follow the state one edge after a decision
//
// Overview of operation
// (R1) light sleep instruction puts the device into light sleep
// (R2) core clock is gated off during light sleep
// (R3) oscillators running before light sleep keep running
// (R4) interrupt ends light sleep at once, no stabilization wait
// (R5) deep sleep instruction puts the device into deep sleep
// (R6) deep sleep halts high-speed system and internal high-speed oscillators
// (R7) interrupt ends deep sleep
// (R8) crystal source selected: wait stabilization time before resuming
// (R9) registers, flags and data memory hold their values while asleep
// (R10) port output latches and buffer states hold while asleep
// (R11) software requests deep sleep only when on the main clock
// (R12) subsystem oscillator is never stopped by a sleep mode
// (R13) light sleep works on main or subsystem clock
// (R14) software stops main-clock peripherals before deep sleep
// (R15) software should clear converter run and comparator bits first
// (R16) reset ends either sleep mode and restarts normally
`timescale 1ns/1ps
`default_nettype none
`include "smc_params.svh"

module standby_mode_controller (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic haltExec,
   input wire logic stopExec,
   input wire logic intReq,
   input wire logic cpuOnSubClk,
   input wire logic xtalSelected,
   input wire logic hsOscReq,
   input wire logic ihsOscReq,
   input wire logic ilsOscReq,
   input wire logic subOscReq,
   output logic cpuClkEn,
   output logic hsOscRun,
   output logic ihsOscRun,
   output logic ilsOscRun,
   output logic subOscRun,
   output logic stateHold,
   output logic inHalt,
   output logic inStop,
   output logic stopRefused
);
   smc_pkg::smc_state_t state;
   smc_pkg::smc_state_t next_state;
   logic next_cpuClkEn;
   logic next_hsOscRun;
   logic next_ihsOscRun;
   logic next_ilsOscRun;
   logic next_subOscRun;
   logic next_stateHold;
   logic next_inHalt;
   logic next_inStop;
   logic next_stopRefused;

   smc_if waitIf ();

   // true for every state in which the core is not running
   function automatic logic smcAsleep(input smc_pkg::smc_state_t s);
      smcAsleep = (s != smc_pkg::SMC_ST_RUN);
   endfunction: smcAsleep

   // true where the high-speed sources must be off
   function automatic logic smcHsOff(input smc_pkg::smc_state_t s);
      smcHsOff = (s == smc_pkg::SMC_ST_STOP);
   endfunction: smcHsOff

   // ****************************************
   // stabilization timer
   // ****************************************
   // start held for the whole wait state, done ends it
   assign waitIf.start = (state == smc_pkg::SMC_ST_WAIT);

   smc_stab_timer stabTimer (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .tif(waitIf.tmr)
   );

   // ****************************************
   // state machine
   // ****************************************
   // pending interrupt at entry wakes on the next edge, or enters the crystal wait state, never lost
   always_comb begin
      next_state = state;
      next_stopRefused = 1'b0;
      case (state)
         smc_pkg::SMC_ST_RUN: begin
            if (stopExec && cpuOnSubClk) begin
               // (R11) deep sleep refused on subclock
               next_stopRefused = 1'b1;
            end else if (stopExec) begin
               // (R5) deep sleep entry
               next_state = smc_pkg::SMC_ST_STOP;
            end else if (haltExec) begin
               // (R1) light sleep entry, (R13) either clock
               next_state = smc_pkg::SMC_ST_HALT;
            end
         end
         smc_pkg::SMC_ST_HALT: begin
            // (R4) immediate interrupt wake
            if (intReq) begin
               next_state = smc_pkg::SMC_ST_RUN;
            end
         end
         smc_pkg::SMC_ST_STOP: begin
            // (R7) interrupt wake, (R8) crystal needs a wait
            if (intReq && xtalSelected) begin
               next_state = smc_pkg::SMC_ST_WAIT;
            end else if (intReq) begin
               next_state = smc_pkg::SMC_ST_RUN;
            end
         end
         smc_pkg::SMC_ST_WAIT: begin
            // (R8) resume after stabilization count
            if (waitIf.done) begin
               next_state = smc_pkg::SMC_ST_RUN;
            end
         end
         default: begin
            next_state = smc_pkg::SMC_ST_RUN;
         end
      endcase
   end

   // ****************************************
   // clock and oscillator controls
   // ****************************************
   // outputs derived from the next state so they line up with it
   always_comb begin
      // (R2) core clock gate
      next_cpuClkEn = !smcAsleep(next_state);
      // (R6) high-speed sources off in deep sleep
      next_hsOscRun = hsOscReq && !smcHsOff(next_state);
      next_ihsOscRun = ihsOscReq && !smcHsOff(next_state);
      // (R3) low-speed keeps its setting in every state
      next_ilsOscRun = ilsOscReq;
      // (R12) subsystem never stopped here
      next_subOscRun = subOscReq;
      // (R9) (R10) freeze core and port state while asleep
      next_stateHold = smcAsleep(next_state);
      next_inHalt = (next_state == smc_pkg::SMC_ST_HALT);
      next_inStop = smcHsOff(next_state);
   end

   // ****************************************
   // registers
   // ****************************************
   // (R16) reset forces the running state
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state <= smc_pkg::SMC_ST_RUN;
         cpuClkEn <= 1'b1;
         hsOscRun <= 1'b0;
         ihsOscRun <= 1'b0;
         ilsOscRun <= 1'b0;
         subOscRun <= 1'b0;
         stateHold <= 1'b0;
         inHalt <= 1'b0;
         inStop <= 1'b0;
         stopRefused <= 1'b0;
      end else begin
         state <= next_state;
         cpuClkEn <= next_cpuClkEn;
         hsOscRun <= next_hsOscRun;
         ihsOscRun <= next_ihsOscRun;
         ilsOscRun <= next_ilsOscRun;
         subOscRun <= next_subOscRun;
         stateHold <= next_stateHold;
         inHalt <= next_inHalt;
         inStop <= next_inStop;
         stopRefused <= next_stopRefused;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   localparam int STAB_CYC = `SMC_STAB_CYC;
   logic [15:0] waitDwell;

   // helper: cycles spent in the wait state so far
   always_ff @(posedge clk_sys) begin
      if (!reset_n || state != smc_pkg::SMC_ST_WAIT) begin
         waitDwell <= 16'h0000;
      end else begin
         waitDwell <= waitDwell + 16'h0001;
      end
   end

   default clocking smcCk @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   // (R1) light sleep entry
   a_halt_entry: assert property (  // (R1)
      (state == smc_pkg::SMC_ST_RUN && haltExec && !stopExec) |=> inHalt && !cpuClkEn)
      else $error("light sleep not entered");

   // (R2) core clock gated
   a_halt_gate: assert property (  // (R2)
      inHalt |-> !cpuClkEn && stateHold)
      else $error("core clock running in light sleep");

   // (R3) oscillators kept in light sleep
   a_halt_osc_kept: assert property (  // (R3)
      (inHalt && $past(hsOscReq) && $past(ihsOscReq)) |-> hsOscRun && ihsOscRun)
      else $error("oscillator dropped in light sleep");

   // (R4) immediate wake
   a_halt_wake: assert property (  // (R4)
      (state == smc_pkg::SMC_ST_HALT && intReq) |=> cpuClkEn && !stateHold)
      else $error("light sleep wake delayed");

   // (R5) (R6) deep sleep entry halts high-speed sources
   a_stop_osc_off: assert property (  // (R6)
      (state == smc_pkg::SMC_ST_RUN && stopExec && !cpuOnSubClk)
      |=> inStop && !hsOscRun && !ihsOscRun && !cpuClkEn)
      else $error("deep sleep did not stop high-speed sources");

   // (R7) wake from deep sleep without crystal
   a_stop_wake: assert property (  // (R7)
      (state == smc_pkg::SMC_ST_STOP && intReq && !xtalSelected) |=> cpuClkEn)
      else $error("deep sleep wake missed");

   // (R8) wait lasts exactly the stabilization count
   a_wait_length: assert property (  // (R8)
      (state == smc_pkg::SMC_ST_WAIT && !cpuClkEn) ##1 (state != smc_pkg::SMC_ST_WAIT)
      |-> cpuClkEn && waitDwell == 16'(STAB_CYC))
      else $error("stabilization wait length wrong");

   // (R9) (R10) hold whenever the core clock is off
   a_hold_asleep: assert property (  // (R9)
      stateHold == !cpuClkEn)
      else $error("state hold out of step with clock gate");

   // (R11) refused deep sleep stays running
   a_stop_refused: assert property (  // (R11)
      (state == smc_pkg::SMC_ST_RUN && stopExec && cpuOnSubClk) |=> stopRefused && cpuClkEn)
      else $error("deep sleep accepted on subclock");

   // (R12) subsystem follows its request
   // first edge after reset release still shows the reset value, so skip it
   a_sub_osc_kept: assert property (  // (R12)
      $past(reset_n) |-> subOscRun == $past(subOscReq))
      else $error("subsystem oscillator stopped");
endmodule: standby_mode_controller

`default_nettype wire

// [verif/smc_core_model.sv]
// Purpose: core and interrupt source model facing the standby controller
// Assumes: an instruction can only execute while the core clock is enabled
// Notes: every change after time zero is made by NBA on the rising edge of clk_sys
`timescale 1ns/1ps
`default_nettype none

module smc_core_model (
   input wire logic clk_sys,
   input wire logic cpuClkEn,
   output logic haltExec,
   output logic stopExec,
   output logic intReq
);
   // quiet core at time zero
   initial begin
      haltExec = 1'h0;
      stopExec = 1'h0;
      intReq = 1'h0;
   end

   // ****************************************
   // instruction issue
   // ****************************************
   // stop comes on the subclock only when the bench asks for a refusal
   // peripherals and converter are taken as already stopped, no pins carry them
   task automatic exec(input logic isStop);
      while (cpuClkEn !== 1'h1) @(posedge clk_sys);
      @(posedge clk_sys);
      haltExec <= ~isStop;
      stopExec <= isStop;
      @(posedge clk_sys);
      haltExec <= 1'h0;
      stopExec <= 1'h0;
   endtask: exec

   // interrupt level, held until the bench lowers it
   task automatic irq(input logic level);
      @(posedge clk_sys);
      intReq <= level;
   endtask: irq
endmodule: smc_core_model

`default_nettype wire

// [verif/standby_mode_controller_tb_top.sv]
// Purpose: self-checking bench of the standby mode controller
// Assumes: stabilization wait of 256 cycles from the params header
// Notes: checks are made 1 ns after the edge so that registered outputs have settled
`timescale 1ns/1ps
`default_nettype none

module standby_mode_controller_tb_top;
   logic clk_sys, reset_n, cpuOnSubClk, xtalSelected;
   logic [3:0] oscReq;
   logic haltExec, stopExec, intReq;
   logic cpuClkEn, hsOscRun, ihsOscRun, ilsOscRun, subOscRun;
   logic stateHold, inHalt, inStop, stopRefused;
   int fails, nTests, cycles, n;

   standby_mode_controller standby_mode_controller_inst (
      .clk_sys(clk_sys), .reset_n(reset_n), .haltExec(haltExec), .stopExec(stopExec),
      .intReq(intReq), .cpuOnSubClk(cpuOnSubClk), .xtalSelected(xtalSelected),
      .hsOscReq(oscReq[3]), .ihsOscReq(oscReq[2]), .ilsOscReq(oscReq[1]),
      .subOscReq(oscReq[0]), .cpuClkEn(cpuClkEn), .hsOscRun(hsOscRun),
      .ihsOscRun(ihsOscRun), .ilsOscRun(ilsOscRun), .subOscRun(subOscRun),
      .stateHold(stateHold), .inHalt(inHalt), .inStop(inStop), .stopRefused(stopRefused));

   smc_core_model smc_core_model_inst (
      .clk_sys(clk_sys), .cpuClkEn(cpuClkEn), .haltExec(haltExec),
      .stopExec(stopExec), .intReq(intReq));

   // ****************************************
   // clock, checks and verdict
   // ****************************************
   initial begin
      clk_sys = 1'h0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      nTests++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask: check

   task automatic report_and_stop();
      $display("comparisons=%0d mismatches=%0d", nTests, fails);
      if (fails == 0 && nTests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask: report_and_stop

   // hang guard, well above the longest scenario
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         report_and_stop();
      end
   end

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_halt(input logic onSub);
      @(posedge clk_sys);
      cpuOnSubClk <= onSub;
      oscReq <= onSub ? 4'h5 : 4'hF;
      smc_core_model_inst.exec(1'h0);
      #1;
      check({inHalt, cpuClkEn, stateHold, inStop}, 16'h000A);
      check({hsOscRun, ihsOscRun, ilsOscRun, subOscRun}, onSub ? 16'h0005 : 16'h000F);
      repeat (4) @(posedge clk_sys);
      #1;
      check({inHalt, cpuClkEn, stateHold}, 16'h0005);
      smc_core_model_inst.irq(1'h1);
      @(posedge clk_sys);
      #1;
      check({inHalt, cpuClkEn, stateHold}, 16'h0002);
      smc_core_model_inst.irq(1'h0);
   endtask: t_halt

   // deep sleep; the wake count starts at the edge that takes the interrupt
   task automatic t_stop(input logic xtal);
      @(posedge clk_sys);
      xtalSelected <= xtal;
      oscReq <= xtal ? 4'hF : 4'hA;
      cpuOnSubClk <= 1'h0;
      smc_core_model_inst.exec(1'h1);
      #1;
      check({inStop, cpuClkEn, stateHold, inHalt}, 16'h000A);
      check({hsOscRun, ihsOscRun, ilsOscRun, subOscRun}, xtal ? 16'h0003 : 16'h0002);
      repeat (3) @(posedge clk_sys);
      #1;
      check({inStop, cpuClkEn, stateHold}, 16'h0005);
      smc_core_model_inst.irq(1'h1);
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
         #1;
         if (n == 1) check({inStop, hsOscRun, ihsOscRun}, xtal ? 16'h0003 : 16'h0002);
      end while (cpuClkEn !== 1'h1 && n < 400);
      check(n[15:0], xtal ? 16'h0101 : 16'h0001);
      smc_core_model_inst.irq(1'h0);
   endtask: t_stop

   // stop on the subclock is refused with a one-cycle pulse
   task automatic t_refuse();
      @(posedge clk_sys);
      cpuOnSubClk <= 1'h1;
      smc_core_model_inst.exec(1'h1);
      #1;
      check({stopRefused, inStop, cpuClkEn}, 16'h0005);
      @(posedge clk_sys);
      #1;
      check({stopRefused, inStop, cpuClkEn}, 16'h0001);
      cpuOnSubClk <= 1'h0;
   endtask: t_refuse

   task automatic t_reset();
      smc_core_model_inst.exec(1'h0);
      @(posedge clk_sys);
      reset_n <= 1'h0;
      @(posedge clk_sys);
      reset_n <= 1'h1;
      #1;
      check({cpuClkEn, inHalt, stateHold, inStop}, 16'h0008);
   endtask: t_reset

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      reset_n = 1'h0;
      cpuOnSubClk = 1'h0;
      xtalSelected = 1'h0;
      oscReq = 4'hF;
      repeat (16) @(posedge clk_sys);
      reset_n <= 1'h1;
      t_halt(1'h0);
      t_halt(1'h1);
      t_stop(1'h1);
      t_stop(1'h0);
      t_refuse();
      t_reset();
      report_and_stop();
   end
endmodule: standby_mode_controller_tb_top

`default_nettype wire
